/* File: pcc_params.svh */
// Purpose: constants of the power and clock control register block
// Assumes: 32-bit apb, one aligned word per register
// Notes: register index times four gives the byte address
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

`define PCC_PWR_CTRL_IDX 12'h00f
`define PCC_PWR_CTRL_ADDR 12'h03c
`define PCC_POR_VALUE 16'h0000
`define PCC_WRITE_MASK 16'h04e5
`define PCC_READ_MASK 16'h04e7
`define PCC_BIT_LOOP_EN 0
`define PCC_BIT_LOCK 1
`define PCC_BIT_CLKOUT_EN 2
`define PCC_BIT_RSTPIN_DIS 5
`define PCC_BIT_REG_STOP_EN 6
`define PCC_BIT_BOD_DIS 7
`define PCC_BIT_SEC_EN 10
`define PCC_CLKSEL_HIGH_FREQ_OSC_DISABLE 2'h3

`endif

/* File: pcc_pkg.sv */
// Purpose: types of the power and clock control register block
// Assumes: constants come from pcc_params.svh
// Notes: all state of the top module lives in pcc_state_t
package pcc_pkg;

  typedef enum logic {
    FLL_IDLE,
    FLL_RUN
  } pcc_fll_t;

  typedef struct packed {
    logic secondary_core_enable;
    logic brownout_disable;
    logic regulator_stop_enable;
    logic reset_pin_disable;
    logic clock_output_enable;
    logic loop_lock_status;
    logic loop_enable;
  } pcc_ctrl_t;

  typedef struct packed {
    pcc_ctrl_t ctrl;
    pcc_fll_t fll;
    logic loop_restart;
    logic high_freq_osc_disable;
    logic strap_pending;
    logic [31:0] prdata;
  } pcc_state_t;

  typedef struct packed {
    logic sclk_out;
    logic sclk_oe_n;
  } pcc_pin_t;

endpackage : pcc_pkg

/* File: pcc_pin_mux.sv */
// Purpose: shared port pin mux for spi clock and core clock output
// Assumes: output enable is active low
// Notes: clock path is combinational so the clock is not divided
`timescale 1ns/1ps

module pcc_pin_mux (
  input wire logic clock_output_enable,
  input wire logic secondary_clk,
  input wire pcc_pkg::pcc_pin_t spi_pin,
  output pcc_pkg::pcc_pin_t pad_pin
);

  // core clock takes the pin over from the spi clock while enabled
  always_comb begin
    if (clock_output_enable) begin
      pad_pin.sclk_out = secondary_clk;
      pad_pin.sclk_oe_n = 1'b0;
    end else begin
      pad_pin = spi_pin;
    end
  end

endmodule : pcc_pin_mux

/* File: pcc_power_ctrl.sv */
// Purpose: power control register with loop, core, regulator and pin control
// Assumes: presetn is the power-on reset, sys_reset_n a synchronous ordinary reset
// Notes: register sits at index 0x0f, byte address 0x3c
//
// Function
// - ordinary resets keep bits except two enables
// - every reset clears clock-out and core enables
// - power-on loads zero, oscillator disable strap
// - whole register readable, lock bit read-only
// - loop enable one starts loop locking
// - loop stops only when not system clock
// - lock clears on enable rise, sets locked
// - lock status clears on stop entry
// - reserved bit ranges always read zero
// - core enable clears on stop; zero disables
// - secondary core cannot access core enable
// - core enable one releases secondary core
// - regulator on keeps brownout detection enabled
// - stop, regulator off: bit selects comparator
// - regulator stop enable; always on outside stop
// - reset pin disable frees the pin
// - clock-out enable drives core clock on pin
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "pcc_params.svh"

module pcc_power_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sys_reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic access_from_secondary,
  input wire logic stop_mode,
  input wire logic stop_entry,
  input wire logic fll_locked,
  input wire logic fll_is_sysclk,
  input wire logic [1:0] clock_select_field,
  input wire logic rst_pin_n,
  input wire logic secondary_clk,
  input wire pcc_pkg::pcc_pin_t spi_pin,
  output pcc_pkg::pcc_pin_t pad_pin,
  output logic loop_run,
  output logic loop_restart,
  output logic high_freq_osc_disable,
  output logic secondary_core_reset_n,
  output logic regulator_on,
  output logic brownout_enable,
  output logic ext_reset_req
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic addr_hit(input logic [11:0] addr);
    addr_hit = (addr == `PCC_PWR_CTRL_ADDR);
  endfunction : addr_hit

  function automatic logic [15:0] pack_ctrl(input pcc_pkg::pcc_ctrl_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[`PCC_BIT_LOOP_EN] = c.loop_enable;
    w[`PCC_BIT_LOCK] = c.loop_lock_status;
    w[`PCC_BIT_CLKOUT_EN] = c.clock_output_enable;
    w[`PCC_BIT_RSTPIN_DIS] = c.reset_pin_disable;
    w[`PCC_BIT_REG_STOP_EN] = c.regulator_stop_enable;
    w[`PCC_BIT_BOD_DIS] = c.brownout_disable;
    w[`PCC_BIT_SEC_EN] = c.secondary_core_enable;
    pack_ctrl = w & `PCC_READ_MASK;
  endfunction : pack_ctrl

  ////////////////////////////////////////////////////////////////////////////
  // byte lane mask

  logic [15:0] lane_mask;
  logic [15:0] write_mask;

  genvar lane;
  generate
    for (lane = 0; lane < 2; lane++) begin : g_lane
      assign lane_mask[lane*8 +: 8] = {8{pstrb[lane]}};
    end
  endgenerate

  always_comb begin
    write_mask = lane_mask & `PCC_WRITE_MASK;
    if (access_from_secondary) begin
      write_mask[`PCC_BIT_SEC_EN] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  pcc_pkg::pcc_state_t state_q;
  pcc_pkg::pcc_state_t state_d;

  logic setup_phase;
  logic access_phase;
  logic wr_hit;
  logic [15:0] cur_word;
  logic [15:0] new_word;
  logic [15:0] rd_word;
  logic loop_rise;

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_hit = access_phase & pwrite & addr_hit(paddr) & sys_reset_n;
  assign cur_word = pack_ctrl(state_q.ctrl);
  assign new_word = (cur_word & ~write_mask) | (pwdata[15:0] & write_mask);
  assign loop_rise = wr_hit & ~state_q.ctrl.loop_enable & new_word[`PCC_BIT_LOOP_EN];

  always_comb begin
    rd_word = pack_ctrl(state_q.ctrl);
    if (access_from_secondary) begin
      rd_word[`PCC_BIT_SEC_EN] = 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    state_d.loop_restart = 1'b0;

    // oscillator disable strap is caught on the first edge after power-on
    if (state_q.strap_pending) begin
      state_d.strap_pending = 1'b0;
      state_d.high_freq_osc_disable = (clock_select_field == `PCC_CLKSEL_HIGH_FREQ_OSC_DISABLE);
    end

    // register write; the lock bit is never taken from the bus
    if (wr_hit) begin
      state_d.ctrl.loop_enable = new_word[`PCC_BIT_LOOP_EN];
      state_d.ctrl.clock_output_enable = new_word[`PCC_BIT_CLKOUT_EN];
      state_d.ctrl.reset_pin_disable = new_word[`PCC_BIT_RSTPIN_DIS];
      state_d.ctrl.regulator_stop_enable = new_word[`PCC_BIT_REG_STOP_EN];
      state_d.ctrl.brownout_disable = new_word[`PCC_BIT_BOD_DIS];
      state_d.ctrl.secondary_core_enable = new_word[`PCC_BIT_SEC_EN];
    end

    // loop control
    case (state_q.fll)
      pcc_pkg::FLL_IDLE: begin
        if (state_q.ctrl.loop_enable) begin
          state_d.fll = pcc_pkg::FLL_RUN;
        end
      end
      pcc_pkg::FLL_RUN: begin
        if (!state_q.ctrl.loop_enable && !fll_is_sysclk) begin
          state_d.fll = pcc_pkg::FLL_IDLE;
        end
      end
      default: begin
        state_d.fll = pcc_pkg::FLL_IDLE;
      end
    endcase

    // lock status: restart and stop entry win over a lock report
    if (loop_rise) begin
      state_d.ctrl.loop_lock_status = 1'b0;
      state_d.loop_restart = 1'b1;
    end else if (stop_entry) begin
      state_d.ctrl.loop_lock_status = 1'b0;
    end else if (state_q.fll == pcc_pkg::FLL_IDLE) begin
      state_d.ctrl.loop_lock_status = 1'b0;
    end else if (fll_locked && !state_q.loop_restart) begin
      state_d.ctrl.loop_lock_status = 1'b1;
    end

    // stop entry drops the secondary core
    if (stop_entry) begin
      state_d.ctrl.secondary_core_enable = 1'b0;
    end

    // ordinary reset clears only the two enables
    if (!sys_reset_n) begin
      state_d.ctrl.clock_output_enable = 1'b0;
      state_d.ctrl.secondary_core_enable = 1'b0;
      state_d.ctrl.loop_enable = state_q.ctrl.loop_enable;
      state_d.ctrl.reset_pin_disable = state_q.ctrl.reset_pin_disable;
      state_d.ctrl.regulator_stop_enable = state_q.ctrl.regulator_stop_enable;
      state_d.ctrl.brownout_disable = state_q.ctrl.brownout_disable;
    end

    // read data is captured in the setup cycle
    if (setup_phase) begin
      state_d.prdata = addr_hit(paddr) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q.ctrl <= pcc_pkg::pcc_ctrl_t'(7'h00);
      state_q.fll <= pcc_pkg::FLL_IDLE;
      state_q.loop_restart <= 1'b0;
      state_q.high_freq_osc_disable <= 1'b0;
      state_q.strap_pending <= 1'b1;
      state_q.prdata <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer

  assign pready = 1'b1;
  assign pslverr = access_phase & ~addr_hit(paddr);
  assign prdata = state_q.prdata;

  ////////////////////////////////////////////////////////////////////////////
  // power, reset and clock outputs

  assign loop_run = (state_q.fll == pcc_pkg::FLL_RUN);
  assign loop_restart = state_q.loop_restart;
  assign high_freq_osc_disable = state_q.high_freq_osc_disable;
  assign secondary_core_reset_n = state_q.ctrl.secondary_core_enable;
  assign regulator_on = ~stop_mode | state_q.ctrl.regulator_stop_enable;
  assign brownout_enable = regulator_on | ~state_q.ctrl.brownout_disable;
  assign ext_reset_req = ~state_q.ctrl.reset_pin_disable & ~rst_pin_n;

  pcc_pin_mux u_pin_mux (
    .clock_output_enable(state_q.ctrl.clock_output_enable),
    .secondary_clk(secondary_clk),
    .spi_pin(spi_pin),
    .pad_pin(pad_pin)
  );

endmodule : pcc_power_ctrl

/* File: pcc_power_ctrl_checker.sv */
// Purpose: concurrent checks on the power control block ports
// Assumes: zero wait apb, sys_reset_n synchronous
// Notes: bound to every pcc_power_ctrl instance
`timescale 1ns/1ps
`include "pcc_params.svh"

module pcc_power_ctrl_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sys_reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic access_from_secondary,
  input wire logic stop_mode,
  input wire logic stop_entry,
  input wire logic fll_is_sysclk,
  input wire logic rst_pin_n,
  input wire pcc_pkg::pcc_pin_t spi_pin,
  input wire pcc_pkg::pcc_pin_t pad_pin,
  input wire logic loop_run,
  input wire logic secondary_core_reset_n,
  input wire logic regulator_on,
  input wire logic brownout_enable,
  input wire logic ext_reset_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  assign wr = psel && penable && pwrite && pready && paddr == `PCC_PWR_CTRL_ADDR && sys_reset_n;
  ////////////////////////////////////////////////////////////////////////////
  property p_resv; pready |-> (prdata & 32'hfffffb18) == 32'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits read nonzero");
  property p_sec_on;
    wr && pstrb[1] && pwdata[10] && !access_from_secondary && !stop_entry |=> secondary_core_reset_n;
  endproperty
  a_sec_on: assert property (p_sec_on) else $error("core not released");
  property p_sec_ro; wr && access_from_secondary && !stop_entry |=> $stable(secondary_core_reset_n); endproperty
  a_sec_ro: assert property (p_sec_ro) else $error("secondary changed core enable");
  property p_stop; stop_entry |=> !secondary_core_reset_n; endproperty
  a_stop: assert property (p_stop) else $error("core enable kept in stop");
  property p_srst; !sys_reset_n |=> !secondary_core_reset_n && pad_pin == spi_pin; endproperty
  a_srst: assert property (p_srst) else $error("enables kept over reset");
  // the loop runs one cycle after a write of enable one lands
  property p_loop; wr && pstrb[0] && pwdata[0] |=> ##1 loop_run; endproperty
  a_loop: assert property (p_loop) else $error("loop not started");
  property p_hold; loop_run && fll_is_sysclk |=> loop_run; endproperty
  a_hold: assert property (p_hold) else $error("loop stopped while system clock");
  property p_reg; !stop_mode |-> regulator_on; endproperty
  a_reg: assert property (p_reg) else $error("regulator off outside stop");
  property p_bod; regulator_on |-> brownout_enable; endproperty
  a_bod: assert property (p_bod) else $error("brownout off with regulator on");
  property p_pin; ext_reset_req |-> !rst_pin_n; endproperty
  a_pin: assert property (p_pin) else $error("reset without pin low");
  property p_err; psel && penable && paddr != `PCC_PWR_CTRL_ADDR |-> pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  c_sec: cover property (wr && pwdata[10]);
  c_stop: cover property (stop_entry);
  c_srst: cover property (!sys_reset_n);
endmodule : pcc_power_ctrl_checker

bind pcc_power_ctrl pcc_power_ctrl_checker pcc_power_ctrl_checker_inst (.*);

/* File: pcc_apb_master.sv */
// Purpose: bus model of both cores driving the apb port
// Assumes: signals change only just after rising edges
// Notes: waits for pready, bounded by the bench timeout
`timescale 1ns/1ps

module pcc_apb_master (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0,
  output logic [3:0] pstrb = 4'hf,
  output logic access_from_secondary = 1'b0
);
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic s,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    access_from_secondary <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : pcc_apb_master

/* File: tb_pcc_power_ctrl.sv */
// Purpose: self-checking bench of the power control register
// Assumes: integer model m mirrors the readable register
// Notes: random writes come from a 16-bit lfsr seeded with 17
`timescale 1ns/1ps
`include "pcc_params.svh"

module tb_pcc_power_ctrl;
  logic pclk = 1'b0, presetn = 1'b0, sys_reset_n = 1'b1, stop_mode = 1'b0, stop_entry = 1'b0;
  logic fll_locked = 1'b0, fll_is_sysclk = 1'b0, rst_pin_n = 1'b1, secondary_clk = 1'b0;
  logic [1:0] clock_select_field = 2'h3;
  // spi request stays idle while the clock output may run
  pcc_pkg::pcc_pin_t spi_pin = '{sclk_out: 1'b1, sclk_oe_n: 1'b1};
  logic psel, penable, pwrite, access_from_secondary, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  pcc_pkg::pcc_pin_t pad_pin;
  logic loop_run, loop_restart, high_freq_osc_disable, secondary_core_reset_n, regulator_on, brownout_enable;
  logic ext_reset_req;
  logic [15:0] v = 16'h0011;
  int m = 0, bad_count = 0, total_checks = 0, cyc = 0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) secondary_clk <= ~secondary_clk;
  pcc_power_ctrl pcc_power_ctrl_inst (.*);
  pcc_apb_master pcc_apb_master_inst (.*);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    #1;
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [31:0] d, input logic s);
    pcc_apb_master_inst.xfer(1'b1, `PCC_PWR_CTRL_ADDR, d, s, q, e);
  endtask : wr
  task automatic rdc;
    pcc_apb_master_inst.xfer(1'b0, `PCC_PWR_CTRL_ADDR, 32'h0, 1'b0, q, e);
    check(q, m);
  endtask : rdc
  task automatic outs;
    logic r;
    r = !stop_mode | m[6];
    check({regulator_on, brownout_enable, ext_reset_req, secondary_core_reset_n, loop_run},
          {r, r | !m[7], !m[5] & !rst_pin_n, m[10], m[0]});
    check(pad_pin, m[2] ? {secondary_clk, 1'b0} : spi_pin);
  endtask : outs
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1 check(high_freq_osc_disable, 1);
    rdc();
    wr(32'hffffffff, 1'b0);
    m = 32'h04e5;
    rdc();
    outs();
    @(posedge pclk) fll_locked <= 1'b1;
    repeat (3) @(posedge pclk);
    m = m | 2;
    rdc();
    @(posedge pclk) fll_is_sysclk <= 1'b1;
    m = m & ~1;
    wr(m, 1'b0);
    rdc();
    check(loop_run, 1);
    @(posedge pclk) fll_is_sysclk <= 1'b0;
    repeat (2) @(posedge pclk);
    #1 check(loop_run, 0);
    m = (m & ~2) | 1;
    wr(m, 1'b0);
    #1 check(loop_restart, 1);
    repeat (3) @(posedge pclk);
    m = m | 2;
    rdc();
    @(posedge pclk) fll_locked <= 1'b0;
    stop_entry <= 1'b1;
    @(posedge pclk) stop_entry <= 1'b0;
    m = m & ~32'h402;
    rdc();
    outs();
    wr(m | 32'h400, 1'b1);
    rdc();
    wr(32'h04e5, 1'b0);
    pcc_apb_master_inst.xfer(1'b0, `PCC_PWR_CTRL_ADDR, 32'h0, 1'b1, q, e);
    check(q, 32'h00e5);
    @(posedge pclk) sys_reset_n <= 1'b0;
    @(posedge pclk) sys_reset_n <= 1'b1;
    m = 32'h00e1;
    rdc();
    pcc_apb_master_inst.xfer(1'b0, 12'h040, 32'h0, 1'b0, q, e);
    check(q, 0);
    check(e, 1);
    repeat (6) begin
      v = lfsr(v);
      @(posedge pclk) stop_mode <= v[15];
      rst_pin_n <= v[14];
      wr(v, 1'b0);
      m = v & 16'h04e5;
      rdc();
      outs();
    end
    // a second power-on reset clears the bits that an ordinary reset keeps
    wr(32'h04e5, 1'b0);
    clock_select_field <= 2'h0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1 check(high_freq_osc_disable, 0);
    m = 0;
    rdc();
    outs();
    end_sim();
  end
endmodule : tb_pcc_power_ctrl
